/* File: pfcc_pkg.sv */
`default_nettype none
package pfcc_pkg;
	localparam int          IDX_W       = 11;
	localparam int          REG_W       = 16;
	localparam int          FM_W        = 6;
	// Register indexes; the byte address is four times the index.
	localparam logic [7:0]  IDX_MODE    = 8'h42;
	localparam logic [7:0]  IDX_PINCLK  = 8'h44;
	localparam logic [7:0]  IDX_LBALARM = 8'h46;
	localparam logic [7:0]  IDX_STATUS  = 8'h50;
	localparam logic [15:0] RST_PINCLK  = 16'h0000;
	localparam logic [15:0] RST_LBALARM = 16'h0000;
	localparam logic [5:0]  RST_MODE    = 6'h00;
	localparam logic [15:0] PINCLK_MASK = 16'h3FFF;
	localparam logic [15:0] LBALARM_MSK = 16'h0FFF;
	// Field positions of the pin and clock control register.
	localparam int B_RXCLK = 13;
	localparam int B_RXFRM = 12;
	localparam int B_RXFPE = 11;
	localparam int B_TXCLK = 10;
	localparam int B_TXFRM = 9;
	localparam int B_TXFPE = 8;
	localparam int B_REFHI = 7;
	localparam int B_REFLO = 6;
	localparam int B_REFLOC = 5;
	localparam int B_LOOP_TIMING_ENABLE = 4;
	localparam int B_CLADIS = 3;
	localparam int B_RX_FRAMER_TIMING_REF = 2;
	localparam int B_TX_FRAMER_TIMING_REF = 1;
	localparam int B_TX_LINE_TIMING_REF = 0;
	// Field positions of the loopback and alarm select register.
	localparam int B_SBLB = 11;
	localparam int B_LBHI = 10;
	localparam int B_LBLO = 8;
	localparam int B_ALBHI = 7;
	localparam int B_ALBLO = 4;
	localparam int B_ALAHI = 3;
	localparam int B_ALALO = 0;
	localparam logic [2:0] LC_UNI = 3'h4;
	localparam logic [2:0] LC_ALL = 3'h7;
	localparam logic [2:0] LC_NONE = 3'h0;
	typedef enum logic [1:0] {FAM_DS3 = 2'b00, FAM_E3 = 2'b01, FAM_STS1 = 2'b10} pfcc_family_e;
	typedef enum logic [2:0] {
		SUB_BASIC = 3'b000, SUB_OHM = 3'b001, SUB_INT_FRAC = 3'b010, SUB_EXT_FRAC = 3'b011,
		SUB_PLCP = 3'b100, SUB_PLCP_OHM = 3'b101, SUB_FLEX_FRAC = 3'b110, SUB_OHM_OCTET = 3'b111
	} pfcc_sub_e;
	typedef enum logic [1:0] {TXS_CLKIN = 2'b00, TXS_RXLINE = 2'b01, TXS_CLOCK_ADAPTER = 2'b10} pfcc_txsrc_e;
	typedef struct packed {
		logic         reserved;
		logic         cell_only;
		logic         overhead_mask_variant;
		logic         clear_channel;
		pfcc_family_e family;
		pfcc_sub_e    sub;
		logic [2:0]   line_codes;
	} pfcc_mode_s;
	localparam int MODE_W = 12;
endpackage : pfcc_pkg
`default_nettype wire

/* File: pfcc_port_config.sv */
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pfcc_port_config #(
	parameter int NUM_PORTS = 4
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [12:0]            wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	input  wire logic [NUM_PORTS-1:0]   rx_output_clock,
	input  wire logic [NUM_PORTS-1:0]   rx_gapped_clock,
	input  wire logic [NUM_PORTS-1:0]   rx_plcp_overhead_clock,
	input  wire logic [NUM_PORTS-1:0]   tx_output_clock,
	input  wire logic [NUM_PORTS-1:0]   tx_gapped_clock,
	input  wire logic [NUM_PORTS-1:0]   tx_plcp_overhead_clock,
	input  wire logic [NUM_PORTS-1:0]   rx_start_of_frame_out,
	input  wire logic [NUM_PORTS-1:0]   rx_data_enable_out,
	input  wire logic [NUM_PORTS-1:0]   tx_start_of_frame_out,
	input  wire logic [NUM_PORTS-1:0]   tx_data_enable_out,
	input  wire logic [NUM_PORTS-1:0]   rx_plcp_ref8k,
	input  wire logic [NUM_PORTS-1:0]   rx_line_clock_pin,
	input  wire logic [NUM_PORTS-1:0]   tx_framer_ref8k,
	input  wire logic [NUM_PORTS-1:0]   tx_clock_input_pin,
	input  wire logic [NUM_PORTS-1:0]   clock_adapter_clock,
	input  wire logic                   global_ref8k,
	output logic [NUM_PORTS-1:0]        rx_clock_pin_o,
	output logic [NUM_PORTS-1:0]        rx_frame_pin_o,
	output logic [NUM_PORTS-1:0]        tx_clock_pin_o,
	output logic [NUM_PORTS-1:0]        tx_frame_pin_o,
	output logic [NUM_PORTS-1:0]        rx_fractional_port_enable,
	output logic [NUM_PORTS-1:0]        tx_fractional_port_enable,
	output logic [NUM_PORTS-1:0]        port_ref8k_o,
	output logic [NUM_PORTS-1:0]        timing_ref8k_o,
	output logic [NUM_PORTS-1:0]        tx_internal_clock_o,
	output logic [NUM_PORTS*2-1:0]      tx_clock_source_o,
	output logic [NUM_PORTS-1:0]        rx_framer_timing_ref,
	output logic [NUM_PORTS-1:0]        tx_framer_timing_ref,
	output logic [NUM_PORTS-1:0]        tx_line_timing_ref,
	output logic [NUM_PORTS-1:0]        system_bus_loopback,
	output logic [NUM_PORTS*3-1:0]      loopback_code,
	output logic [NUM_PORTS*4-1:0]      alarm_out_select_a,
	output logic [NUM_PORTS*4-1:0]      alarm_out_select_b,
	output logic [NUM_PORTS*12-1:0]     port_mode_o
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	typedef struct packed {
		logic                                  ack;
		logic [31:0]                           dat;
		logic [NUM_PORTS-1:0][5:0]             fm;
		logic [NUM_PORTS-1:0][15:0]            pinclk;
		logic [NUM_PORTS-1:0][15:0]            lbalarm;
		logic [NUM_PORTS-1:0][11:0]            mode;
		logic [NUM_PORTS-1:0]                  rx_clk_pin;
		logic [NUM_PORTS-1:0]                  rx_frm_pin;
		logic [NUM_PORTS-1:0]                  tx_clk_pin;
		logic [NUM_PORTS-1:0]                  tx_frm_pin;
		logic [NUM_PORTS-1:0]                  port_ref;
		logic [NUM_PORTS-1:0]                  timing_ref;
		logic [NUM_PORTS-1:0]                  tx_clk;
		logic [NUM_PORTS-1:0][1:0]             tx_src;
	} pfcc_state_s;

	pfcc_state_s state_r;
	pfcc_state_s state_nxt;

	logic [10:0] idx;
	logic [1:0]  sel_port;
	logic        req;
	logic        hit;

	function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [15:0] new_v,
		input logic [1:0] sel);
		lane_merge = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
	endfunction : lane_merge

	function automatic pfcc_pkg::pfcc_mode_s decode_mode(input logic [5:0] fm);
		pfcc_pkg::pfcc_mode_s m;
		m = '0;
		m.clear_channel = fm[5];
		if (!fm[5]) begin
			m.family = fm[4] ? pfcc_pkg::FAM_E3 : pfcc_pkg::FAM_DS3;
			m.sub = pfcc_pkg::pfcc_sub_e'(fm[2:0]);
			m.reserved = (fm[2:0] == 3'h7) || (fm[4:3] == 2'h3 && fm[2:1] == 2'h2);
		end else begin
			m.family = fm[4] ? pfcc_pkg::FAM_E3
				: (fm[3] ? pfcc_pkg::FAM_STS1 : pfcc_pkg::FAM_DS3);
			m.reserved = fm[2];
			m.sub = (fm[1:0] == 2'h1) ? pfcc_pkg::SUB_OHM
				: ((fm[1:0] == 2'h3) ? pfcc_pkg::SUB_OHM_OCTET : pfcc_pkg::SUB_BASIC);
		end
		m.overhead_mask_variant = (m.sub == pfcc_pkg::SUB_OHM) ||
			(m.sub == pfcc_pkg::SUB_PLCP_OHM) || (m.sub == pfcc_pkg::SUB_OHM_OCTET);
		m.cell_only = (m.sub == pfcc_pkg::SUB_PLCP) || (m.sub == pfcc_pkg::SUB_PLCP_OHM);
		m.line_codes = m.reserved ? pfcc_pkg::LC_NONE
			: (m.overhead_mask_variant ? pfcc_pkg::LC_UNI : pfcc_pkg::LC_ALL);
		return m;
	endfunction : decode_mode

	assign idx      = wb_adr_i[12:2];
	assign sel_port = idx[10:9];
	assign req      = wb_cyc_i && wb_stb_i && !state_r.ack;
	assign hit      = (!idx[8]) && (32'(sel_port) < NUM_PORTS);

	always_comb begin
		pfcc_pkg::pfcc_mode_s m;
		logic [15:0] pc;
		logic [15:0] lb;
		logic        lb_on;
		m = '0;
		pc = '0;
		lb = '0;
		lb_on = 1'b0;
		state_nxt = state_r;
		state_nxt.ack = req;
		if (req) begin
			state_nxt.dat = '0;
			if (hit) begin
				case (idx[7:0])
					pfcc_pkg::IDX_MODE: begin
						state_nxt.dat[5:0] = state_r.fm[sel_port];
						if (wb_we_i && wb_sel_i[0]) begin
							state_nxt.fm[sel_port] = wb_dat_i[5:0];
						end
					end
					pfcc_pkg::IDX_PINCLK: begin
						state_nxt.dat[15:0] = state_r.pinclk[sel_port];
						if (wb_we_i) begin
							state_nxt.pinclk[sel_port] = lane_merge(state_r.pinclk[sel_port],
								wb_dat_i[15:0], wb_sel_i[1:0]) & pfcc_pkg::PINCLK_MASK;
						end
					end
					pfcc_pkg::IDX_LBALARM: begin
						state_nxt.dat[15:0] = state_r.lbalarm[sel_port];
						if (wb_we_i) begin
							state_nxt.lbalarm[sel_port] = lane_merge(state_r.lbalarm[sel_port],
								wb_dat_i[15:0], wb_sel_i[1:0]) & pfcc_pkg::LBALARM_MSK;
						end
					end
					pfcc_pkg::IDX_STATUS: begin
						state_nxt.dat[11:0] = state_r.mode[sel_port];
					end
					default: begin
						state_nxt.dat = '0;
					end
				endcase
			end
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			m = decode_mode(state_r.fm[p]);
			pc = state_r.pinclk[p];
			lb = state_r.lbalarm[p];
			state_nxt.mode[p] = m;
			if (pc[pfcc_pkg::B_RXCLK]) begin
				state_nxt.rx_clk_pin[p] = rx_output_clock[p];
			end else if (m.cell_only) begin
				state_nxt.rx_clk_pin[p] = rx_plcp_overhead_clock[p];
			end else if (m.sub != pfcc_pkg::SUB_BASIC) begin
				state_nxt.rx_clk_pin[p] = rx_gapped_clock[p];
			end else begin
				state_nxt.rx_clk_pin[p] = 1'b0;
			end
			state_nxt.rx_frm_pin[p] = pc[pfcc_pkg::B_RXFRM] ? rx_start_of_frame_out[p]
				: rx_data_enable_out[p];
			if (pc[pfcc_pkg::B_TXCLK]) begin
				state_nxt.tx_clk_pin[p] = tx_output_clock[p];
			end else begin
				state_nxt.tx_clk_pin[p] = m.cell_only ? tx_plcp_overhead_clock[p]
					: tx_gapped_clock[p];
			end
			state_nxt.tx_frm_pin[p] = pc[pfcc_pkg::B_TXFRM] ? tx_start_of_frame_out[p]
				: tx_data_enable_out[p];
			if (!pc[pfcc_pkg::B_REFHI]) begin
				state_nxt.port_ref[p] = rx_plcp_ref8k[p];
			end else if (!pc[pfcc_pkg::B_REFLO]) begin
				state_nxt.port_ref[p] = rx_line_clock_pin[p];
			end else begin
				state_nxt.port_ref[p] = tx_framer_ref8k[p];
			end
			state_nxt.timing_ref[p] = pc[pfcc_pkg::B_REFLOC] ? state_nxt.port_ref[p]
				: global_ref8k;
			// fixed priority: loopback, loop timing, adapter disable, adapter
			lb_on = (lb[pfcc_pkg::B_LBHI:pfcc_pkg::B_LBLO] != 3'h0);
			if (lb_on) begin
				state_nxt.tx_src[p] = pfcc_pkg::TXS_RXLINE;
			end else if (pc[pfcc_pkg::B_LOOP_TIMING_ENABLE]) begin
				state_nxt.tx_src[p] = pc[pfcc_pkg::B_CLADIS] ? pfcc_pkg::TXS_RXLINE
					: pfcc_pkg::TXS_CLOCK_ADAPTER;
			end else if (pc[pfcc_pkg::B_CLADIS]) begin
				state_nxt.tx_src[p] = pfcc_pkg::TXS_CLKIN;
			end else begin
				state_nxt.tx_src[p] = pfcc_pkg::TXS_CLOCK_ADAPTER;
			end
			case (state_nxt.tx_src[p])
				pfcc_pkg::TXS_RXLINE: begin
					state_nxt.tx_clk[p] = rx_line_clock_pin[p];
				end
				pfcc_pkg::TXS_CLOCK_ADAPTER: begin
					state_nxt.tx_clk[p] = clock_adapter_clock[p];
				end
				default: begin
					state_nxt.tx_clk[p] = tx_clock_input_pin[p];
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= '0;
			for (int p = 0; p < NUM_PORTS; p++) begin
				state_r.fm[p]      <= pfcc_pkg::RST_MODE;
				state_r.pinclk[p]  <= pfcc_pkg::RST_PINCLK;
				state_r.lbalarm[p] <= pfcc_pkg::RST_LBALARM;
			end
		end else begin
			state_r <= state_nxt;
		end
	end

	assign wb_ack_o          = state_r.ack;
	assign wb_dat_o          = state_r.dat;
	assign rx_clock_pin_o    = state_r.rx_clk_pin;
	assign rx_frame_pin_o    = state_r.rx_frm_pin;
	assign tx_clock_pin_o    = state_r.tx_clk_pin;
	assign tx_frame_pin_o    = state_r.tx_frm_pin;
	assign port_ref8k_o      = state_r.port_ref;
	assign timing_ref8k_o    = state_r.timing_ref;
	assign tx_internal_clock_o = state_r.tx_clk;
	assign tx_clock_source_o = state_r.tx_src;
	assign port_mode_o       = state_r.mode;

	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : g_fields
			assign rx_fractional_port_enable[g] = state_r.pinclk[g][pfcc_pkg::B_RXFPE];
			assign tx_fractional_port_enable[g] = state_r.pinclk[g][pfcc_pkg::B_TXFPE];
			assign rx_framer_timing_ref[g] = state_r.pinclk[g][pfcc_pkg::B_RX_FRAMER_TIMING_REF];
			assign tx_framer_timing_ref[g] = state_r.pinclk[g][pfcc_pkg::B_TX_FRAMER_TIMING_REF];
			assign tx_line_timing_ref[g]   = state_r.pinclk[g][pfcc_pkg::B_TX_LINE_TIMING_REF];
			assign system_bus_loopback[g] = state_r.lbalarm[g][pfcc_pkg::B_SBLB];
			assign loopback_code[g*3 +: 3] = state_r.lbalarm[g][pfcc_pkg::B_LBHI:pfcc_pkg::B_LBLO];
			assign alarm_out_select_b[g*4 +: 4] =
				state_r.lbalarm[g][pfcc_pkg::B_ALBHI:pfcc_pkg::B_ALBLO];
			assign alarm_out_select_a[g*4 +: 4] =
				state_r.lbalarm[g][pfcc_pkg::B_ALAHI:pfcc_pkg::B_ALALO];
		end
	endgenerate

	a_ack_single_pulse: assert property (state_r.ack |=> !state_r.ack)
		else $error("ack held longer than one cycle");
	a_framed_e3_family: assert property (
		(!state_r.fm[0][5] && state_r.fm[0][4:3] == 2'b10) |=>
		(!state_r.mode[0][8] && state_r.mode[0][7:6] == 2'b01))
		else $error("framed E3 family not decoded");
	a_framed_sub_mode: assert property (
		(!state_r.fm[0][5] && state_r.fm[0][4] == 1'b0 && state_r.fm[0][2:0] != 3'h7) |=>
		state_r.mode[0][5:3] == $past(state_r.fm[0][2:0]))
		else $error("framed sub-mode mismatch");
	a_plcp_cell_only: assert property (
		(!state_r.fm[0][5] && state_r.fm[0][2:1] == 2'b10) |=> state_r.mode[0][10])
		else $error("PLCP mode not marked cell only");
	a_ohm_unipolar: assert property (
		(state_r.fm[0][2:0] == 3'b001) |=> state_r.mode[0][2:0] == 3'h4)
		else $error("overhead-mask mode allows non-unipolar code");
	a_clear_sts1_octet: assert property (
		(state_r.fm[0] == 6'b101011) |=>
		(state_r.mode[0][8:6] == 3'b110 && state_r.mode[0][5:3] == 3'b111))
		else $error("STS-1 octet aligned clear channel misdecoded");
	a_write_pinclk: assert property (
		(req && wb_we_i && wb_adr_i == 13'h0110 && wb_sel_i[1:0] == 2'b11) |=>
		(state_r.pinclk[0] == ($past(wb_dat_i[15:0]) & 16'h3FFF) && state_r.ack))
		else $error("pin clock register write lost");
	a_rx_clock_pin: assert property (
		state_r.pinclk[0][13] |=> rx_clock_pin_o[0] == $past(rx_output_clock[0]))
		else $error("receive clock pin not showing output clock");
	a_rx_frame_pin: assert property (
		!state_r.pinclk[0][12] |=> rx_frame_pin_o[0] == $past(rx_data_enable_out[0]))
		else $error("receive frame pin not showing data enable");
	a_global_ref: assert property (
		!state_r.pinclk[0][5] |=> timing_ref8k_o[0] == $past(global_ref8k))
		else $error("timing reference not global");
	a_loop_timing_src: assert property (
		(state_r.pinclk[0][4] && state_r.lbalarm[0][10:8] == 3'h0 && !state_r.pinclk[0][3])
		|=> tx_clock_source_o[1:0] == 2'b10)
		else $error("loop timing not on adapter clock");
	a_clkin_src: assert property (
		(!state_r.pinclk[0][4] && state_r.pinclk[0][3] && state_r.lbalarm[0][10:8] == 3'h0)
		|=> tx_clock_source_o[1:0] == 2'b00)
		else $error("adapter disable not on clock input");
	a_rx_sof_pin: assert property (
		state_r.pinclk[0][12] |=> rx_frame_pin_o[0] == $past(rx_start_of_frame_out[0]))
		else $error("receive frame pin not showing start of frame");
	a_tx_clock_pin: assert property (
		state_r.pinclk[0][10] |=> tx_clock_pin_o[0] == $past(tx_output_clock[0]))
		else $error("transmit clock pin not showing output clock");
	a_tx_frame_pin: assert property (
		!state_r.pinclk[0][9] |=> tx_frame_pin_o[0] == $past(tx_data_enable_out[0]))
		else $error("transmit frame pin not showing data enable");
	a_rx_frac_write: assert property (
		(req && wb_we_i && wb_adr_i == 13'h0110 && wb_sel_i[1]) |=>
		rx_fractional_port_enable[0] == $past(wb_dat_i[11]))
		else $error("receive fractional enable not written");
	a_tx_frac_write: assert property (
		(req && wb_we_i && wb_adr_i == 13'h0110 && wb_sel_i[1]) |=>
		tx_fractional_port_enable[0] == $past(wb_dat_i[8]))
		else $error("transmit fractional enable not written");
	a_port_ref_plcp: assert property (
		!state_r.pinclk[0][7] |=> port_ref8k_o[0] == $past(rx_plcp_ref8k[0]))
		else $error("port reference not on receive PLCP output");
	a_port_ref_line: assert property (
		state_r.pinclk[0][7:6] == 2'b10 |=> port_ref8k_o[0] == $past(rx_line_clock_pin[0]))
		else $error("port reference not on receive line clock");
	a_local_ref: assert property (
		state_r.pinclk[0][5] |=> timing_ref8k_o[0] == port_ref8k_o[0])
		else $error("timing reference not local");
	a_timing_ref_write: assert property (
		(req && wb_we_i && wb_adr_i == 13'h0110 && wb_sel_i[0]) |=>
		{rx_framer_timing_ref[0], tx_framer_timing_ref[0], tx_line_timing_ref[0]} ==
		$past(wb_dat_i[2:0]))
		else $error("timing reference selects not written");
	a_loopback_fields: assert property (
		(req && wb_we_i && wb_adr_i == 13'h0118 && wb_sel_i[1:0] == 2'b11) |=>
		{system_bus_loopback[0], loopback_code[2:0], alarm_out_select_b[3:0],
		alarm_out_select_a[3:0]} == $past(wb_dat_i[11:0]))
		else $error("loopback and alarm fields misplaced");
	a_port_isolation: assert property (
		(req && wb_we_i && wb_adr_i == 13'h0910) |=> $stable(state_r.pinclk[0]))
		else $error("write to another port changed port zero");
	a_loopback_src: assert property (
		(state_r.lbalarm[0][10:8] != 3'h0) |=> tx_clock_source_o[1:0] == 2'b01)
		else $error("loopback not on receive line clock");
endmodule : pfcc_port_config
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int NP = 4;
	localparam int TIMEOUT = 5000;
	localparam logic [5:0]  FM_TAB [0:15] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
		6'h08, 6'h14, 6'h1E, 6'h22, 6'h28, 6'h2B, 6'h31, 6'h3A, 6'h07};
	localparam logic [11:0] MX_TAB [0:15] = '{12'h007, 12'h20C, 12'h017, 12'h01F, 12'h427,
		12'h62C, 12'h037, 12'h007, 12'h467, 12'h077, 12'h107, 12'h187, 12'h3BC, 12'h34C, 12'h147,
		12'hA38};
	localparam logic [5:0]  CF_FM  [0:6] = '{6'h00, 6'h00, 6'h04, 6'h04, 6'h02, 6'h02, 6'h00};
	localparam logic [15:0] CF_REG [0:6] = '{16'h0000, 16'h3FFF, 16'h2A95, 16'h1568, 16'h00D8,
		16'h0080, 16'h0020};
	localparam logic [15:0] CF_LB  [0:6] = '{16'h0000, 16'h0FFF, 16'h0000, 16'h0000, 16'h0000,
		16'h0135, 16'h0A5C};
	logic              ref_clk;
	logic              rst;
	logic              wb_cyc_i;
	logic              wb_stb_i;
	logic              wb_we_i;
	logic [12:0]       wb_adr_i;
	logic [3:0]        wb_sel_i;
	logic [31:0]       wb_dat_i;
	logic [31:0]       wb_dat_o;
	logic              wb_ack_o;
	logic [15:0]       w_pat;
	logic [NP-1:0]     rx_clock_pin_o, rx_frame_pin_o, tx_clock_pin_o, tx_frame_pin_o;
	logic [NP-1:0]     rx_fractional_port_enable, tx_fractional_port_enable;
	logic [NP-1:0]     port_ref8k_o, timing_ref8k_o, tx_internal_clock_o;
	logic [NP*2-1:0]   tx_clock_source_o;
	logic [NP-1:0]     rx_framer_timing_ref, tx_framer_timing_ref, tx_line_timing_ref;
	logic [NP-1:0]     system_bus_loopback;
	logic [NP*3-1:0]   loopback_code;
	logic [NP*4-1:0]   alarm_out_select_a, alarm_out_select_b;
	logic [NP*12-1:0]  port_mode_o;
	logic [31:0]       rdat;
	logic [15:0]       cr, lb, w;
	logic [1:0]        src;
	logic              plcp, basic, rf;
	int                err_total = 0;
	int                total_checks = 0;
	int                cyc_cnt = 0;

	pfcc_port_config #(.NUM_PORTS(NP)) pfcc_port_config_inst (
		.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.rx_output_clock({NP{w_pat[0]}}), .rx_gapped_clock({NP{w_pat[1]}}),
		.rx_plcp_overhead_clock({NP{w_pat[2]}}), .tx_output_clock({NP{w_pat[3]}}),
		.tx_gapped_clock({NP{w_pat[4]}}), .tx_plcp_overhead_clock({NP{w_pat[5]}}),
		.rx_start_of_frame_out({NP{w_pat[6]}}), .rx_data_enable_out({NP{w_pat[7]}}),
		.tx_start_of_frame_out({NP{w_pat[8]}}), .tx_data_enable_out({NP{w_pat[9]}}),
		.rx_plcp_ref8k({NP{w_pat[10]}}), .rx_line_clock_pin({NP{w_pat[11]}}),
		.tx_framer_ref8k({NP{w_pat[12]}}), .tx_clock_input_pin({NP{w_pat[13]}}),
		.clock_adapter_clock({NP{w_pat[14]}}), .global_ref8k(w_pat[15]),
		.rx_clock_pin_o(rx_clock_pin_o), .rx_frame_pin_o(rx_frame_pin_o),
		.tx_clock_pin_o(tx_clock_pin_o), .tx_frame_pin_o(tx_frame_pin_o),
		.rx_fractional_port_enable(rx_fractional_port_enable),
		.tx_fractional_port_enable(tx_fractional_port_enable),
		.port_ref8k_o(port_ref8k_o), .timing_ref8k_o(timing_ref8k_o),
		.tx_internal_clock_o(tx_internal_clock_o), .tx_clock_source_o(tx_clock_source_o),
		.rx_framer_timing_ref(rx_framer_timing_ref), .tx_framer_timing_ref(tx_framer_timing_ref),
		.tx_line_timing_ref(tx_line_timing_ref), .system_bus_loopback(system_bus_loopback),
		.loopback_code(loopback_code), .alarm_out_select_a(alarm_out_select_a),
		.alarm_out_select_b(alarm_out_select_b), .port_mode_o(port_mode_o)
	);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	always @(posedge ref_clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == TIMEOUT) begin
			err_total = err_total + 1;
			finish_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wb_xfer(input logic we, input logic [12:0] adr, input logic [3:0] sel,
		input logic [31:0] wdat, output logic [31:0] rd_val);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= wdat;
		do begin
			@(posedge ref_clk);
		end while (wb_ack_o !== 1'b1);
		rd_val = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		check(32'(wb_ack_o), 32'h1);
	endtask : wb_xfer

	task automatic wr(input logic [12:0] adr, input logic [3:0] sel, input logic [31:0] d);
		logic [31:0] junk;
		wb_xfer(1'b1, adr, sel, d, junk);
	endtask : wr

	task automatic rd(input logic [12:0] adr, output logic [31:0] d);
		wb_xfer(1'b0, adr, 4'hF, 32'h0000_0000, d);
	endtask : rd

	function automatic logic [12:0] pa(input int p, input logic [7:0] off);
		return 13'((p * 32'h200 + int'(off)) * 4);
	endfunction : pa

	function automatic logic [15:0] pv(input int p);
		return 16'hFFFF - 16'(p) * 16'h0111;
	endfunction : pv

	initial begin
		rst = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 13'h0000;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0000_0000;
		w_pat = 16'h0000;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		for (int p = 0; p < NP; p++) begin
			rd(pa(p, pfcc_pkg::IDX_PINCLK), rdat);
			check(rdat, 32'h0000_0000);
			rd(pa(p, pfcc_pkg::IDX_LBALARM), rdat);
			check(rdat, 32'h0000_0000);
		end
		$display("test reset_values done");
		for (int p = 0; p < NP; p++) begin
			wr(pa(p, pfcc_pkg::IDX_PINCLK), 4'h3, {16'hFFFF, pv(p)});
			wr(pa(p, pfcc_pkg::IDX_LBALARM), 4'h3, {16'hFFFF, pv(p)});
		end
		wr(pa(1, pfcc_pkg::IDX_PINCLK), 4'h2, 32'h0000_0000);
		for (int p = 0; p < NP; p++) begin
			rd(pa(p, pfcc_pkg::IDX_PINCLK), rdat);
			check(rdat, {16'h0, pv(p) & 16'h3FFF & ((p == 1) ? 16'h00FF : 16'hFFFF)});
			rd(pa(p, pfcc_pkg::IDX_LBALARM), rdat);
			check(rdat, {16'h0, pv(p) & 16'h0FFF});
		end
		rd(13'h0004, rdat);
		check(rdat, 32'h0000_0000);
		wr(pa(0, pfcc_pkg::IDX_STATUS), 4'hF, 32'hFFFF_FFFF);
		rd(pa(0, pfcc_pkg::IDX_STATUS), rdat);
		check(rdat, 32'h0000_0007);
		$display("test port_copies done");
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd(pa(3, pfcc_pkg::IDX_PINCLK), rdat);
		check(rdat, 32'h0000_0000);
		rd(pa(2, pfcc_pkg::IDX_LBALARM), rdat);
		check(rdat, 32'h0000_0000);
		$display("test mid_reset done");
		for (int i = 0; i < 16; i++) begin
			wr(pa(0, pfcc_pkg::IDX_MODE), 4'h1, 32'(FM_TAB[i]));
			repeat (2) @(posedge ref_clk);
			rd(pa(0, pfcc_pkg::IDX_STATUS), rdat);
			check(rdat, 32'(MX_TAB[i]));
			check(32'(port_mode_o[11:0]), 32'(MX_TAB[i]));
		end
		$display("test mode_decode done");
		for (int c = 0; c < 7; c++) begin
			wr(pa(0, pfcc_pkg::IDX_MODE), 4'h1, 32'(CF_FM[c]));
			wr(pa(0, pfcc_pkg::IDX_PINCLK), 4'h3, 32'(CF_REG[c]));
			wr(pa(0, pfcc_pkg::IDX_LBALARM), 4'h3, 32'(CF_LB[c]));
			cr = CF_REG[c];
			lb = CF_LB[c];
			plcp = (CF_FM[c][2:1] == 2'b10);
			basic = (CF_FM[c][2:0] == 3'b000);
			src = (lb[10:8] != 3'h0) ? 2'b01 : (cr[4] ? (cr[3] ? 2'b01 : 2'b10) :
				(cr[3] ? 2'b00 : 2'b10));
			for (int i = 0; i < 17; i++) begin
				w = (i == 16) ? 16'hFFFF : 16'(32'h1 << i);
				w_pat <= w;
				repeat (3) @(posedge ref_clk);
				rf = cr[7] ? (cr[6] ? w[12] : w[11]) : w[10];
				check(32'(rx_clock_pin_o[0]), 32'(cr[13] ? w[0] : (plcp ? w[2] : (basic ? 1'b0 : w[1]))));
				check(32'(rx_frame_pin_o[0]), 32'(cr[12] ? w[6] : w[7]));
				check(32'(tx_clock_pin_o[0]), 32'(cr[10] ? w[3] : (plcp ? w[5] : w[4])));
				check(32'(tx_frame_pin_o[0]), 32'(cr[9] ? w[8] : w[9]));
				check(32'(port_ref8k_o[0]), 32'(rf));
				check(32'(timing_ref8k_o[0]), 32'(cr[5] ? rf : w[15]));
				check(32'(tx_internal_clock_o[0]), 32'(src == 2'b00 ? w[13] : (src == 2'b01 ? w[11] : w[14])));
			end
			check(32'(rx_fractional_port_enable[0]), 32'(cr[11]));
			check(32'(tx_fractional_port_enable[0]), 32'(cr[8]));
			check(32'(tx_clock_source_o[1:0]), 32'(src));
			check(32'({rx_framer_timing_ref[0], tx_framer_timing_ref[0], tx_line_timing_ref[0]}), 32'(cr[2:0]));
			check(32'({system_bus_loopback[0], loopback_code[2:0], alarm_out_select_b[3:0], alarm_out_select_a[3:0]}), 32'(lb[11:0]));
		end
		$display("test pin_clock_select done");
		finish_test();
	end
endmodule : tb
`default_nettype wire
